// ==== cbrf_access_check.sv ====
// Purpose: classify one register access and flag privilege faults
// Assumes: decoder presents selector, class and op kind each cycle
// Notes:   pure combinational; instantiated once per port
`timescale 1ns/100ps
module cbrf_access_check
	import cbrf_pkg::*;
(
	input  wire logic       valid_in,
	input  wire logic       write_in,
	input  wire cbrf_sel_t  sel_in,
	input  wire cbrf_cls_t  cls_in,
	input  wire logic       addr_calc_in,
	input  wire cbrf_lvl_t  level_in,
	output logic            priv_fault_out,
	output logic            illegal_out
);
	logic legacy;

	always_comb begin
		legacy         = (cls_in == CBRF_CLS_LEGACY_ARITH) || (cls_in == CBRF_CLS_LEGACY_XFER);
		priv_fault_out = 1'b0;
		illegal_out    = 1'b0;
		if (valid_in) begin
			case (sel_in)
				CBRF_SEL_SSP, CBRF_SEL_USP: begin
					if (level_in == CBRF_LVL_USER) begin
						priv_fault_out = 1'b1;
					end else if (level_in == CBRF_LVL_SUPER && sel_in == CBRF_SEL_SSP) begin
						priv_fault_out = 1'b1;
					end
				end
				CBRF_SEL_SW32: begin
					if (level_in == CBRF_LVL_USER) begin
						priv_fault_out = 1'b1;
					end
				end
				CBRF_SEL_EXT: begin
					illegal_out = legacy;
				end
				CBRF_SEL_ADDR: begin
					if (cls_in == CBRF_CLS_LEGACY_ARITH && !addr_calc_in) begin
						illegal_out = 1'b1;
					end
				end
				CBRF_SEL_PC: begin
					illegal_out = write_in;
				end
				default: begin
					illegal_out = 1'b0;
				end
			endcase
		end
	end
endmodule

// ==== cbrf_chk.sv ====
// Purpose: port-level checker for the banked register file
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound onto cbrf_regfile from the testbench
`timescale 1ns/100ps
module cbrf_chk
	import cbrf_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        clk_en_in,
	input wire logic        rd_valid_in,
	input wire cbrf_sel_t   rd_sel_in,
	input wire logic        wr_valid_in,
	input wire cbrf_sel_t   wr_sel_in,
	input wire logic [31:0] wr_data_in,
	input wire logic        fp_instr_in,
	input wire logic        irq_accept_in,
	input wire logic        store_via_addr_in,
	input wire logic [31:0] rd_data_out,
	input wire logic [31:0] pc_out,
	input wire logic [31:0] status_word_out,
	input wire logic [31:0] saved_status_out,
	input wire logic        bank_select_bit_out,
	input wire logic        user_level_out,
	input wire logic        priv_fault_out,
	input wire logic        illegal_access_out,
	input wire logic        fpu_disable_fault_out,
	input wire logic        store_full_word_out
);
	// ==========
	// Properties
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_rsv; status_word_out[31:21] == 11'h000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits nonzero");
	property p_rst; $fell(sys_rst_in) |-> pc_out == CBRF_PC_RESET && status_word_out == CBRF_SW_RESET; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_fpu; clk_en_in && fp_instr_in |=> fpu_disable_fault_out == !$past(status_word_out[20]); endproperty
	a_fpu: assert property (p_fpu) else $error("fpu disable fault wrong");
	property p_irq;
		clk_en_in && irq_accept_in |=> !bank_select_bit_out && !user_level_out
			&& saved_status_out == $past(status_word_out);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt entry wrong");
	property p_priv;
		clk_en_in && rd_valid_in && status_word_out[16] && !status_word_out[19]
			&& rd_sel_in inside {CBRF_SEL_SSP, CBRF_SEL_USP, CBRF_SEL_SW32} |=> priv_fault_out && rd_data_out == '0;
	endproperty
	a_priv: assert property (p_priv) else $error("user access not refused");
	property p_pcw; clk_en_in && wr_valid_in && wr_sel_in == CBRF_SEL_PC |=> illegal_access_out; endproperty
	a_pcw: assert property (p_pcw) else $error("pc write not refused");
	property p_bank;
		clk_en_in && wr_valid_in && wr_sel_in == CBRF_SEL_SW32 && !irq_accept_in && !status_word_out[16]
			|=> bank_select_bit_out == $past(wr_data_in[18]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank bit not updated");
	property p_sw16;
		clk_en_in && wr_valid_in && wr_sel_in == CBRF_SEL_SW16 && !irq_accept_in
			|=> $stable(status_word_out[31:16]);
	endproperty
	a_sw16: assert property (p_sw16) else $error("legacy view touched upper half");
	property p_store; store_full_word_out == store_via_addr_in; endproperty
	a_store: assert property (p_store) else $error("store width wrong");
	property p_hold;
		!clk_en_in |=> $stable(status_word_out) && $stable(pc_out) && $stable(rd_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved with clock enable low");
	c_bank: cover property (bank_select_bit_out);
	c_priv: cover property (priv_fault_out);
	c_irq: cover property (irq_accept_in ##1 !user_level_out);
endmodule

// ==== cbrf_pipe_model.sv ====
// Purpose: pipeline partner that advances the program counter
// Assumes: one PC step per enabled cycle while go_in is high
// Notes:   load and value both lag go_in by one edge, as a fetch stage would
`timescale 1ns/100ps
module cbrf_pipe_model
	import cbrf_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        go_in,
	output logic             pc_load_out,
	output logic [31:0]      pc_value_out
);
	always_ff @(posedge ref_clk_in) begin
		pc_load_out <= go_in & ~sys_rst_in;
		if (sys_rst_in)
			pc_value_out <= CBRF_PC_RESET;
		else if (go_in)
			pc_value_out <= pc_value_out + CBRF_PC_STEP;
	end
endmodule

// ==== cbrf_pkg.sv ====
// Purpose: constants and types shared by the banked register file
// Assumes: 32-bit core, one clock domain
// Notes:   status word field positions and reset values live here
package cbrf_pkg;
	localparam int          CBRF_XLEN        = 32;
	localparam logic [31:0] CBRF_PC_RESET    = 32'h4000_0000;
	localparam logic [31:0] CBRF_PC_STEP     = 32'h0000_0001;
	localparam logic [31:0] CBRF_SW_RESET    = 32'h0000_0000;
	// Writable mask of the status word; reserved and trace bits stay zero
	localparam logic [31:0] CBRF_SW_WMASK    = 32'h001f_3f0f;
	localparam logic [31:0] CBRF_LOW_MASK    = 32'h0000_ffff;
	localparam logic [31:0] CBRF_HIGH_MASK   = 32'hffff_0000;
	localparam int          CBRF_FE_BIT      = 20;
	localparam int          CBRF_ML_BIT      = 19;
	localparam int          CBRF_BANK_BIT    = 18;
	localparam int          CBRF_NMI_DISABLE_BIT_BIT    = 17;
	localparam int          CBRF_USER_BIT    = 16;
	localparam int          CBRF_TRACE_BIT   = 15;
	localparam int          CBRF_IE_BIT      = 11;
	localparam logic [1:0]  CBRF_ALIGN_MASK  = 2'h3;

	// Register selector seen by the decoder
	typedef enum logic [3:0] {
		CBRF_SEL_ADDR  = 4'h0,   // address pointer, index 0..3
		CBRF_SEL_DATA  = 4'h1,   // data operation register, index 0..3
		CBRF_SEL_EXT   = 4'h2,   // extended general register, index 0..7
		CBRF_SEL_SP    = 4'h3,   // generic stack pointer
		CBRF_SEL_SSP   = 4'h4,   // supervisor stack pointer by name
		CBRF_SEL_USP   = 4'h5,   // user stack pointer by name
		CBRF_SEL_PC    = 4'h6,
		CBRF_SEL_SW32  = 4'h7,   // extended status word
		CBRF_SEL_SW16  = 4'h8    // legacy status view
	} cbrf_sel_t;

	// Instruction class of the access
	typedef enum logic [1:0] {
		CBRF_CLS_LEGACY_ARITH = 2'h0,
		CBRF_CLS_LEGACY_XFER  = 2'h1,
		CBRF_CLS_EXTENDED     = 2'h2,
		CBRF_CLS_PARALLEL     = 2'h3
	} cbrf_cls_t;

	typedef enum logic [1:0] {
		CBRF_LVL_SUPER,
		CBRF_LVL_USER,
		CBRF_LVL_MONITOR
	} cbrf_lvl_t;
endpackage

// ==== cbrf_regfile.sv ====
// Purpose: banked architectural register file with status word and PC
// Assumes: single core clock, synchronous active-high reset, clock enable
// Notes:   one read port and one write port per cycle; write-port faults suppress that write
//          general registers live in the state struct but are left out of reset
//
// Operation
// - Address and data registers exist twice; bank bit picks bank 0 or 1.
// - Only the selected bank is reachable; no access spans both banks.
// - Legacy transfers through an address pointer always store full words.
// - Legacy arithmetic uses address registers only for add, subtract, compare.
// - Data registers hold full 32-bit values; narrowing handled by extends.
// - Eight extended registers serve extended and parallel ops, not legacy.
// - General and stack registers have no defined reset value.
// - Generic SP aliases supervisor pointer at supervisor, user pointer at user.
// - Naming explicit stack pointers at user level raises privilege exception.
// - Monitor may name both pointers, supervisor only user pointer.
// - Interrupt entry pushes via supervisor pointer; misalignment means double fault.
// - PC resets to 0x40000000, read-only, holds current instruction address.
// - Status word via moves; legacy view reads upper zero, ignores upper writes.
// - Upper status half accessed at user level raises privilege exception.
// - Status bits 31 to 21 read zero; software writes zero.
// - Floating-point instruction with FPU enable clear raises FPU disable exception.
// - Control bits at 20..16 each reset to zero.
// - Accepted interrupt clears bank bit after the status word is saved.
// - User-level select zero means supervisor, one means user.
`timescale 1ns/100ps
module cbrf_regfile
	import cbrf_pkg::*;
#(
	parameter int XLEN    = CBRF_XLEN,
	parameter int NBANKED = 4,
	parameter int NEXT    = 8
)
(
	input  wire logic             ref_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             clk_en_in,
	// Read port
	input  wire logic             rd_valid_in,
	input  wire cbrf_sel_t        rd_sel_in,
	input  wire logic [2:0]       rd_idx_in,
	input  wire cbrf_cls_t        rd_cls_in,
	input  wire logic             rd_addr_calc_in,
	output logic [XLEN-1:0]       rd_data_out,
	// Write port
	input  wire logic             wr_valid_in,
	input  wire cbrf_sel_t        wr_sel_in,
	input  wire logic [2:0]       wr_idx_in,
	input  wire cbrf_cls_t        wr_cls_in,
	input  wire logic             wr_addr_calc_in,
	input  wire logic [XLEN-1:0]  wr_data_in,
	// Pipeline control
	input  wire logic             pc_load_in,
	input  wire logic [XLEN-1:0]  pc_value_in,
	input  wire logic             fp_instr_in,
	input  wire logic             irq_accept_in,
	input  wire logic             flags_we_in,
	input  wire logic [3:0]       flags_in,
	input  wire logic             store_via_addr_in,
	// Status outputs
	output logic [XLEN-1:0]       pc_out,
	output logic [XLEN-1:0]       status_word_out,
	output logic [XLEN-1:0]       saved_status_out,
	output logic [XLEN-1:0]       stack_ptr_out,
	output logic                  bank_select_bit_out,
	output logic                  user_level_out,
	output logic                  priv_fault_out,
	output logic                  illegal_access_out,
	output logic                  fpu_disable_fault_out,
	output logic                  ssp_misaligned_out,
	output logic                  store_full_word_out
);
	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [1:0][NBANKED-1:0][XLEN-1:0] addr_regs;
		logic [1:0][NBANKED-1:0][XLEN-1:0] data_regs;
		logic [NEXT-1:0][XLEN-1:0]         ext_regs;
		logic [XLEN-1:0]                   supervisor_stack_pointer;
		logic [XLEN-1:0]                   user_stack_pointer;
		logic [XLEN-1:0]                   pc;
		logic [XLEN-1:0]                   sw;
		logic [XLEN-1:0]                   saved_sw;
		logic [XLEN-1:0]                   rd_data;
		logic                              priv_fault;
		logic                              illegal;
		logic                              fpu_fault;
	} cbrf_state_t;

	cbrf_state_t st;
	cbrf_state_t next_st;

	// Stack pointers as seen by the SP alias and the outputs
	logic [XLEN-1:0] ssp_reg;
	logic [XLEN-1:0] usp_reg;

	assign ssp_reg = st.supervisor_stack_pointer;
	assign usp_reg = st.user_stack_pointer;

	// ==========================================================
	// Level decode
	// ==========================================================
	cbrf_lvl_t level;
	logic      bank;
	logic      rd_pfault;
	logic      rd_illegal;
	logic      wr_pfault;
	logic      wr_illegal;
	logic      wr_ok;

	always_comb begin
		if (st.sw[CBRF_ML_BIT]) begin
			level = CBRF_LVL_MONITOR;
		end else if (st.sw[CBRF_USER_BIT]) begin
			level = CBRF_LVL_USER;
		end else begin
			level = CBRF_LVL_SUPER;
		end
	end

	// Bank taken from the registered word: a write changes later accesses only
	assign bank = st.sw[CBRF_BANK_BIT];

	cbrf_access_check u_rd_check (
		.valid_in       (rd_valid_in),
		.write_in       (1'b0),
		.sel_in         (rd_sel_in),
		.cls_in         (rd_cls_in),
		.addr_calc_in   (rd_addr_calc_in),
		.level_in       (level),
		.priv_fault_out (rd_pfault),
		.illegal_out    (rd_illegal)
	);

	cbrf_access_check u_wr_check (
		.valid_in       (wr_valid_in),
		.write_in       (1'b1),
		.sel_in         (wr_sel_in),
		.cls_in         (wr_cls_in),
		.addr_calc_in   (wr_addr_calc_in),
		.level_in       (level),
		.priv_fault_out (wr_pfault),
		.illegal_out    (wr_illegal)
	);

	assign wr_ok = clk_en_in && wr_valid_in && !wr_pfault && !wr_illegal && !irq_accept_in;

	// ==========================================================
	// Fault decode
	// ==========================================================
	logic any_pfault;
	logic any_illegal;
	logic fp_blocked;

	// Faults are registered so the pipeline sees them beside the read data
	assign any_pfault  = rd_pfault || wr_pfault;
	assign any_illegal = rd_illegal || wr_illegal;
	assign fp_blocked  = fp_instr_in && !st.sw[CBRF_FE_BIT];

	// ==========================================================
	// Write decode
	// ==========================================================
	logic wr_addr_en;
	logic wr_data_en;
	logic wr_ext_en;
	logic wr_ssp_en;
	logic wr_usp_en;
	logic wr_sw32_en;
	logic wr_sw16_en;

	// One enable per target; SP resolves to the pointer of the current level
	always_comb begin
		wr_addr_en = 1'b0;
		wr_data_en = 1'b0;
		wr_ext_en  = 1'b0;
		wr_ssp_en  = 1'b0;
		wr_usp_en  = 1'b0;
		wr_sw32_en = 1'b0;
		wr_sw16_en = 1'b0;
		if (wr_ok) begin
			case (wr_sel_in)
				CBRF_SEL_ADDR: wr_addr_en = 1'b1;
				CBRF_SEL_DATA: wr_data_en = 1'b1;
				CBRF_SEL_EXT:  wr_ext_en  = 1'b1;
				CBRF_SEL_SP: begin
					if (level == CBRF_LVL_USER) begin
						wr_usp_en = 1'b1;
					end else begin
						wr_ssp_en = 1'b1;
					end
				end
				CBRF_SEL_SSP:  wr_ssp_en  = 1'b1;
				CBRF_SEL_USP:  wr_usp_en  = 1'b1;
				CBRF_SEL_SW32: wr_sw32_en = 1'b1;
				CBRF_SEL_SW16: wr_sw16_en = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux
	// ==========================================================
	function automatic logic [XLEN-1:0] read_reg(input cbrf_sel_t sel, input logic [2:0] idx);
		logic [1:0] bidx;
		bidx = idx[1:0];
		case (sel)
			CBRF_SEL_ADDR: read_reg = st.addr_regs[bank][bidx];
			CBRF_SEL_DATA: read_reg = st.data_regs[bank][bidx];
			CBRF_SEL_EXT:  read_reg = st.ext_regs[idx];
			CBRF_SEL_SP:   read_reg = (level == CBRF_LVL_USER) ? usp_reg : ssp_reg;
			CBRF_SEL_SSP:  read_reg = ssp_reg;
			CBRF_SEL_USP:  read_reg = usp_reg;
			CBRF_SEL_PC:   read_reg = st.pc;
			CBRF_SEL_SW32: read_reg = st.sw;
			CBRF_SEL_SW16: read_reg = st.sw & CBRF_LOW_MASK;
			default:       read_reg = '0;
		endcase
	endfunction

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		next_st = st;
		if (clk_en_in) begin
			next_st.priv_fault = any_pfault;
			next_st.illegal    = any_illegal;
			next_st.fpu_fault  = fp_blocked;
			if (rd_valid_in && !rd_pfault && !rd_illegal) begin
				next_st.rd_data = read_reg(rd_sel_in, rd_idx_in);
			end else begin
				next_st.rd_data = '0;
			end
			if (pc_load_in) begin
				next_st.pc = pc_value_in;
			end
			if (flags_we_in) begin
				next_st.sw[3:0] = flags_in;
			end
			if (wr_sw32_en) begin
				next_st.sw = wr_data_in & CBRF_SW_WMASK;
			end else if (wr_sw16_en) begin
				// Upper half kept: legacy view cannot change control bits
				next_st.sw = (st.sw & CBRF_HIGH_MASK) | (wr_data_in & CBRF_SW_WMASK & CBRF_LOW_MASK);
			end
			if (wr_addr_en) begin
				next_st.addr_regs[bank][wr_idx_in[1:0]] = wr_data_in;
			end
			if (wr_data_en) begin
				next_st.data_regs[bank][wr_idx_in[1:0]] = wr_data_in;
			end
			if (wr_ext_en) begin
				next_st.ext_regs[wr_idx_in] = wr_data_in;
			end
			if (wr_ssp_en) begin
				next_st.supervisor_stack_pointer = wr_data_in;
			end
			if (wr_usp_en) begin
				next_st.user_stack_pointer = wr_data_in;
			end
			if (irq_accept_in) begin
				// Old word saved first, then bank and level forced
				next_st.saved_sw                 = st.sw;
				next_st.sw[CBRF_BANK_BIT]        = 1'b0;
				next_st.sw[CBRF_USER_BIT]        = 1'b0;
				next_st.sw[CBRF_IE_BIT]          = 1'b0;
			end
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			// General registers and stack pointers keep whatever they hold
			st.pc         <= CBRF_PC_RESET;
			st.sw         <= CBRF_SW_RESET;
			st.saved_sw   <= '0;
			st.rd_data    <= '0;
			st.priv_fault <= 1'b0;
			st.illegal    <= 1'b0;
			st.fpu_fault  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign rd_data_out           = st.rd_data;
	assign pc_out                = st.pc;
	assign status_word_out       = st.sw;
	assign saved_status_out      = st.saved_sw;
	assign stack_ptr_out         = (level == CBRF_LVL_USER) ? usp_reg : ssp_reg;
	assign bank_select_bit_out   = st.sw[CBRF_BANK_BIT];
	assign user_level_out        = (level == CBRF_LVL_USER);
	assign priv_fault_out        = st.priv_fault;
	assign illegal_access_out    = st.illegal;
	assign fpu_disable_fault_out = st.fpu_fault;
	assign ssp_misaligned_out    = |(ssp_reg[1:0] & CBRF_ALIGN_MASK);
	assign store_full_word_out   = store_via_addr_in;
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench for cbrf_regfile
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes:   writes always use the extended class
`timescale 1ns/100ps
module tb
	import cbrf_pkg::*;
;
	logic ref_clk_in = 0, sys_rst_in = 1, clk_en_in = 1, rd_valid_in = 0, wr_valid_in = 0, go = 0;
	logic rd_addr_calc_in = 0, wr_addr_calc_in = 0, fp_instr_in = 0, irq_accept_in = 0;
	logic flags_we_in = 0, store_via_addr_in = 0, pc_load_in, bank_select_bit_out, user_level_out;
	logic priv_fault_out, illegal_access_out, fpu_disable_fault_out, ssp_misaligned_out, store_full_word_out;
	cbrf_sel_t rd_sel_in = CBRF_SEL_PC, wr_sel_in = CBRF_SEL_PC;
	cbrf_cls_t rd_cls_in = CBRF_CLS_EXTENDED, wr_cls_in = CBRF_CLS_EXTENDED;
	logic [2:0] rd_idx_in = 0, wr_idx_in = 0;
	logic [3:0] flags_in = 4'h9;
	logic [31:0] wr_data_in = 0, pc_value_in, rd_data_out, pc_out, status_word_out, saved_status_out, stack_ptr_out;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	cbrf_regfile dut (.*);
	cbrf_pipe_model u_pipe (.ref_clk_in, .sys_rst_in, .go_in(go), .pc_load_out(pc_load_in), .pc_value_out(pc_value_in));
	initial forever #20 ref_clk_in = ~ref_clk_in;
	// ==========
	// Tasks
	task automatic give_verdict;
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input cbrf_sel_t s, input logic [2:0] i, input logic [31:0] d);
		@(posedge ref_clk_in);
		wr_valid_in <= 1;
		wr_sel_in <= s;
		wr_idx_in <= i;
		wr_data_in <= d;
		@(posedge ref_clk_in);
		wr_valid_in <= 0;
		#1;
	endtask
	task automatic rd(input cbrf_sel_t s, input logic [2:0] i, input cbrf_cls_t c, input logic [31:0] e);
		@(posedge ref_clk_in);
		rd_valid_in <= 1;
		rd_sel_in <= s;
		rd_idx_in <= i;
		rd_cls_in <= c;
		@(posedge ref_clk_in);
		rd_valid_in <= 0;
		#1;
		chk(rd_data_out, e);
	endtask
	// Pulses fp, irq, flags and store-via-address for one request
	task automatic ctl(input logic [3:0] m);
		@(posedge ref_clk_in);
		{fp_instr_in, irq_accept_in, flags_we_in, store_via_addr_in} <= m;
		@(posedge ref_clk_in);
		{fp_instr_in, irq_accept_in, flags_we_in, store_via_addr_in} <= 4'h0;
		#1;
	endtask
	// Hang guard: the sequence needs well under 300 cycles
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			give_verdict;
		end
	end
	// ==========
	// Sequence
	initial begin
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 0;
		#1;
		chk(pc_out, CBRF_PC_RESET);
		chk(status_word_out, CBRF_SW_RESET);
		wr(CBRF_SEL_ADDR, 3'h0, 32'h0a0a_0a0a);
		wr(CBRF_SEL_DATA, 3'h3, 32'h8000_00ff);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0004_0000);
		chk(bank_select_bit_out, 32'h1);
		wr(CBRF_SEL_ADDR, 3'h0, 32'h1b1b_1b1b);
		rd(CBRF_SEL_ADDR, 3'h0, CBRF_CLS_EXTENDED, 32'h1b1b_1b1b);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0);
		rd(CBRF_SEL_ADDR, 3'h0, CBRF_CLS_EXTENDED, 32'h0a0a_0a0a);
		rd(CBRF_SEL_DATA, 3'h3, CBRF_CLS_EXTENDED, 32'h8000_00ff);
		rd(CBRF_SEL_ADDR, 3'h0, CBRF_CLS_LEGACY_ARITH, 32'h0);
		chk(illegal_access_out, 32'h1);
		rd_addr_calc_in <= 1'b1;
		rd(CBRF_SEL_ADDR, 3'h0, CBRF_CLS_LEGACY_ARITH, 32'h0a0a_0a0a);
		chk(illegal_access_out, 32'h0);
		rd_addr_calc_in <= 1'b0;
		for (int i = 0; i < 8; i++)
			wr(CBRF_SEL_EXT, i[2:0], {29'h1000_0000, i[2:0]});
		for (int i = 0; i < 8; i++)
			rd(CBRF_SEL_EXT, i[2:0], CBRF_CLS_PARALLEL, {29'h1000_0000, i[2:0]});
		rd(CBRF_SEL_EXT, 3'h7, CBRF_CLS_LEGACY_XFER, 32'h0);
		chk(illegal_access_out, 32'h1);
		wr(CBRF_SEL_SW32, 3'h0, 32'hffff_ffff);
		chk(status_word_out, CBRF_SW_WMASK);
		wr(CBRF_SEL_SW16, 3'h0, 32'h0);
		chk(status_word_out, 32'h001f_0000);
		rd(CBRF_SEL_SW16, 3'h0, CBRF_CLS_EXTENDED, 32'h0);
		wr(CBRF_SEL_SSP, 3'h0, 32'h1000);
		wr(CBRF_SEL_USP, 3'h0, 32'h2000);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0);
		chk(stack_ptr_out, 32'h1000);
		chk(ssp_misaligned_out, 32'h0);
		rd(CBRF_SEL_SSP, 3'h0, CBRF_CLS_EXTENDED, 32'h0);
		chk(priv_fault_out, 32'h1);
		rd(CBRF_SEL_USP, 3'h0, CBRF_CLS_EXTENDED, 32'h2000);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0001_0000);
		chk(stack_ptr_out, 32'h2000);
		rd(CBRF_SEL_USP, 3'h0, CBRF_CLS_EXTENDED, 32'h0);
		chk(priv_fault_out, 32'h1);
		rd(CBRF_SEL_SW32, 3'h0, CBRF_CLS_EXTENDED, 32'h0);
		chk(priv_fault_out, 32'h1);
		wr(CBRF_SEL_SW16, 3'h0, 32'h0000_0a05);
		chk(status_word_out, 32'h0001_0a05);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0004_0000);
		chk(priv_fault_out, 32'h1);
		chk(status_word_out, 32'h0001_0a05);
		wr(CBRF_SEL_SSP, 3'h0, 32'h3000);
		chk(priv_fault_out, 32'h1);
		ctl(4'h4);
		chk(saved_status_out, 32'h0001_0a05);
		chk(status_word_out, 32'h0000_0205);
		chk(stack_ptr_out, 32'h1000);
		ctl(4'h8);
		chk(fpu_disable_fault_out, 32'h1);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0010_0000);
		@(posedge ref_clk_in);
		store_via_addr_in <= 1'b1;
		@(posedge ref_clk_in);
		#1;
		chk(store_full_word_out, 32'h1);
		store_via_addr_in <= 1'b0;
		#1;
		chk(store_full_word_out, 32'h0);
		ctl(4'h9);
		chk(fpu_disable_fault_out, 32'h0);
		ctl(4'h2);
		chk(status_word_out, 32'h0010_0009);
		wr(CBRF_SEL_SW32, 3'h0, 32'h0008_0000);
		wr(CBRF_SEL_SSP, 3'h0, 32'h1002);
		chk(ssp_misaligned_out, 32'h1);
		wr(CBRF_SEL_PC, 3'h0, 32'h0);
		chk(illegal_access_out, 32'h1);
		chk(pc_out, CBRF_PC_RESET);
		// Clock enable low: a legal write must not land
		clk_en_in <= 1'b0;
		wr(CBRF_SEL_SW32, 3'h0, 32'h0004_0000);
		chk(status_word_out, 32'h0008_0000);
		clk_en_in <= 1'b1;
		go <= 1;
		repeat (3) @(posedge ref_clk_in);
		go <= 0;
		@(posedge ref_clk_in);
		#1;
		chk(pc_out, CBRF_PC_RESET + 32'h3);
		// Second reset in mid-run brings PC and status back
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		#1;
		chk(pc_out, CBRF_PC_RESET);
		chk(status_word_out, CBRF_SW_RESET);
		give_verdict;
	end
endmodule
bind cbrf_regfile cbrf_chk u_chk (.*);
